/* adrt_map.svh */
`ifndef ADRT_MAP_SVH
`define ADRT_MAP_SVH

// Width of the active-low multiplexed system port
`define ADRT_SYS_W      24
// Width of the local data bus
`define ADRT_DATA_W     16
// Highest and lowest local address bit numbers
`define ADRT_LA_HI      20
`define ADRT_LA_LO      1
// Address field carried on the system port (bits 18 down to 3)
`define ADRT_AF_HI      18
`define ADRT_AF_LO      3
// Width of the stored address field
`define ADRT_AF_W       16
// Upper system byte, taken from or sent to local bits 15..8
`define ADRT_SYS_UB_HI  23
`define ADRT_SYS_UB_LO  16
// Local address bit that selects strobed output of the low system half
`define ADRT_A1_BIT     1
// Number of memory address outputs
`define ADRT_DRAM_W     10
// Synchroniser depth in flip-flops
`define ADRT_SYNC_DEPTH 2
// Reset value of the device end's output enables
`define ADRT_OE_RST     1'b0
// Level a floating line settles to (pull-up on active-low lines)
`define ADRT_FLOAT_LVL  1'b1

`endif

/* adrt_pkg.sv */
`include "adrt_map.svh"

package adrt_pkg;

   // Control pins that the controller side drives
   typedef struct packed {
      logic local_strobe;       // Local data strobe, rising edge stores
      logic addr_capture_clk;   // Address capture clock, rising edge stores
      logic data_capture_clk;   // Data capture clock, rising edge stores
      logic data_source_select; // Low: live lines, high: stored data
      logic row_col_select;     // Memory address row/column select
      logic addr_ack_n;         // Active-low local address enable
      logic local_low_half_en;  // Enables local data in low-half mode
      logic local_high_half_en; // Enables local data bits 15..8 only
      logic sys_out_en_n;       // Active-low system port output enable
      logic start_cycle;        // Drives address onto system port
   } adrt_ctrl_t;

   // One sample of every line the device end reads
   typedef struct packed {
      logic [`ADRT_SYS_W-1:0]          sys;  // System port lines
      logic [`ADRT_LA_HI:`ADRT_LA_LO]  la;   // Local address lines
      logic [`ADRT_DATA_W-1:0]         ld;   // Local data lines
      adrt_ctrl_t                      ctrl; // Control pins
   } adrt_pins_t;

   // All state of the device end
   typedef struct packed {
      adrt_pins_t                      meta;      // First synchroniser stage
      adrt_pins_t                      samp;      // Second synchroniser stage
      logic [2:0]                      strb_prev; // Previous strobe levels
      logic [`ADRT_AF_W-1:0]           addr_reg;  // Stored address lines
      logic [`ADRT_SYS_W-1:0]          data_reg;  // Stored data lines
      logic [`ADRT_DATA_W-1:0]         sys_hold;  // Strobed low system half
      logic [`ADRT_AF_W-1:0]           la_o;      // Local address drive
      logic                            la_oe;     // Local address enable
      logic [`ADRT_DATA_W-1:0]         ld_o;      // Local data drive
      logic [`ADRT_DATA_W-1:0]         ld_oe;     // Local data enables
      logic [`ADRT_SYS_W-1:0]          sys_o;     // System port drive
      logic [`ADRT_SYS_W-1:0]          sys_oe;    // System port enables
      logic [`ADRT_DRAM_W-1:0]         dram;      // Memory address drive
   } adrt_dev_state_t;

   // Lines the controller end watches
   typedef struct packed {
      logic [`ADRT_SYS_W-1:0]          sys;
      logic [`ADRT_LA_HI:`ADRT_LA_LO]  la;
      logic [`ADRT_DATA_W-1:0]         ld;
      logic [`ADRT_DRAM_W-1:0]         dram;
   } adrt_view_t;

   // All state of the controller end
   typedef struct packed {
      adrt_view_t                      meta;   // First synchroniser stage
      adrt_view_t                      samp;   // Second synchroniser stage
      adrt_ctrl_t                      ctrl;   // Control pins driven
      logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_o;   // Local address drive
      logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_oe;  // Local address enables
      logic [`ADRT_DATA_W-1:0]         ld_o;   // Local data drive
      logic                            ld_oe;  // Local data enable
      logic [`ADRT_SYS_W-1:0]          sys_o;  // System port drive
      logic [`ADRT_SYS_W-1:0]          sys_oe; // System port enables
   } adrt_host_state_t;

endpackage : adrt_pkg

/* adrt_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface adrt_link_if;
   import adrt_pkg::*;

   // Control pins, driven by the controller end
   adrt_ctrl_t                      ctrl;
   // System port: both ends drive, resolved below
   logic [`ADRT_SYS_W-1:0]          sys_dev_o;
   logic [`ADRT_SYS_W-1:0]          sys_dev_oe;
   logic [`ADRT_SYS_W-1:0]          sys_host_o;
   logic [`ADRT_SYS_W-1:0]          sys_host_oe;
   logic [`ADRT_SYS_W-1:0]          sys_line;
   // Local address bus
   logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_dev_o;
   logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_dev_oe;
   logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_host_o;
   logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_host_oe;
   logic [`ADRT_LA_HI:`ADRT_LA_LO]  la_line;
   // Local data bus
   logic [`ADRT_DATA_W-1:0]         ld_dev_o;
   logic [`ADRT_DATA_W-1:0]         ld_dev_oe;
   logic [`ADRT_DATA_W-1:0]         ld_host_o;
   logic [`ADRT_DATA_W-1:0]         ld_host_oe;
   logic [`ADRT_DATA_W-1:0]         ld_line;
   // Memory address outputs of the device
   logic [`ADRT_DRAM_W-1:0]         dram_addr_out;

   // Wire level: device first, then controller, else the pull level
   assign sys_line = (sys_dev_oe & sys_dev_o)
                   | (~sys_dev_oe & sys_host_oe & sys_host_o)
                   | (~sys_dev_oe & ~sys_host_oe & {`ADRT_SYS_W{`ADRT_FLOAT_LVL}});
   assign la_line  = (la_dev_oe & la_dev_o)
                   | (~la_dev_oe & la_host_oe & la_host_o)
                   | (~la_dev_oe & ~la_host_oe & {`ADRT_LA_HI{`ADRT_FLOAT_LVL}});
   assign ld_line  = (ld_dev_oe & ld_dev_o)
                   | (~ld_dev_oe & ld_host_oe & ld_host_o)
                   | (~ld_dev_oe & ~ld_host_oe & {`ADRT_DATA_W{`ADRT_FLOAT_LVL}});

   // Documented transceiver end
   modport dev_mp (
      input  ctrl, sys_line, la_line, ld_line,
      output sys_dev_o, sys_dev_oe, la_dev_o, la_dev_oe, ld_dev_o, ld_dev_oe,
      output dram_addr_out
   );

   // Controller and local processor end
   modport host_mp (
      input  sys_line, la_line, ld_line, dram_addr_out,
      output ctrl, sys_host_o, sys_host_oe, la_host_o, la_host_oe,
      output ld_host_o, ld_host_oe
   );

endinterface : adrt_link_if

`default_nettype wire

/* adrt_device_end.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - System port carries address, then data
// - Address capture edge stores system lines 18..3
// - Acknowledge low drives stored address locally
// - Acknowledge high floats; edge still loads address
// - Data capture edge stores all 24 lines
// - Select low: live lines; high: stored data
// - Stored data changes only at capture edge
// - Both enables low float; never both high
// - Low enable: byte-swapped complement of lines 15..0
// - High enable: upper byte; low byte floats
// - Enable high, start low: system port floats
// - Start cycle drives complemented address 18..3
// - Controller never enables output during start
// - A1 low: local data to system, transparent
// - A1 high: low half updates on strobe
// - Controller drives remaining lines 23..19 and 2..0
// - Row select low: complemented even address bits
// - Row select high: odd address bits
module adrt_device_end
   import adrt_pkg::*;
(
   // Clock and reset
   input  wire logic                        mclk_in,
   input  wire logic                        srst_in,
   // Link to the controller and local bus
   adrt_link_if.dev_mp                      link,
   // Captured register contents, for observation
   output logic      [`ADRT_AF_W-1:0]       addr_reg_out,
   output logic      [`ADRT_SYS_W-1:0]      data_reg_out
);

   // Complement of a 16-bit word with its bytes exchanged
   function automatic logic [`ADRT_DATA_W-1:0] adrt_cross16(
      input logic [`ADRT_DATA_W-1:0] v
   );
      adrt_cross16 = ~{v[7:0], v[15:8]};
   endfunction : adrt_cross16

   // Memory address: odd bits as they are, even bits complemented
   function automatic logic [`ADRT_DRAM_W-1:0] adrt_dram_map(
      input logic [`ADRT_LA_HI:`ADRT_LA_LO] a,
      input logic                          col
   );
      logic [`ADRT_DRAM_W-1:0] m;
      m = '0;
      for (int i = 0; i < `ADRT_DRAM_W; i++) begin
         if (col) begin
            m[i] = a[2*i+1];
         end else begin
            m[i] = ~a[2*i+2];
         end
      end
      adrt_dram_map = m;
   endfunction : adrt_dram_map

   adrt_dev_state_t               st_reg;     // Registered state
   adrt_dev_state_t               st_next;    // Next state
   adrt_pins_t                    p;          // Synchronised pin sample
   adrt_ctrl_t                    c;          // Synchronised control pins
   logic                          acap;       // Address capture edge
   logic                          dcap;       // Data capture edge
   logic                          lstb;       // Local strobe edge
   logic [`ADRT_SYS_W-1:0]        dsrc;       // Source of local data drive
   logic [`ADRT_DATA_W-1:0]       sys_low;    // Next low half of system port
   logic [`ADRT_AF_W-1:0]         addr_src;   // Address being driven

   // Next-state logic for all of the transceiver
   always_comb begin
      st_next  = st_reg;
      p        = st_reg.samp;
      c        = st_reg.samp.ctrl;
      dsrc     = '0;
      sys_low  = '0;
      addr_src = '0;

      // Two-flop synchronisers on every pin; only samp is read below
      st_next.meta.sys  = link.sys_line;
      st_next.meta.la   = link.la_line;
      st_next.meta.ld   = link.ld_line;
      st_next.meta.ctrl = link.ctrl;
      st_next.samp      = st_reg.meta;

      // Rising edges of the three strobes
      st_next.strb_prev = {c.addr_capture_clk, c.data_capture_clk, c.local_strobe};
      acap = c.addr_capture_clk & ~st_reg.strb_prev[2];
      dcap = c.data_capture_clk & ~st_reg.strb_prev[1];
      lstb = c.local_strobe & ~st_reg.strb_prev[0];

      // Address phase of the system port is stored on its capture edge
      if (acap) begin
         st_next.addr_reg = p.sys[`ADRT_AF_HI:`ADRT_AF_LO];
      end
      addr_src = acap ? p.sys[`ADRT_AF_HI:`ADRT_AF_LO] : st_reg.addr_reg;

      // Local address drive: complement of stored lines, ack gates the enable
      st_next.la_o  = ~addr_src;
      st_next.la_oe = ~c.addr_ack_n;

      // Data phase of the system port is stored on its capture edge
      if (dcap) begin
         st_next.data_reg = p.sys;
      end

      // Live lines or stored data feed the local data buffer
      if (c.data_source_select) begin
         dsrc = dcap ? p.sys : st_reg.data_reg;
      end else begin
         dsrc = p.sys;
      end

      // Local data enables; both low or both high leaves the bus floating
      st_next.ld_o  = '0;
      st_next.ld_oe = '0;
      if (c.local_low_half_en && !c.local_high_half_en) begin
         // Low-half mode: byte-swapped complement of lines 15..0
         st_next.ld_o  = adrt_cross16(dsrc[`ADRT_DATA_W-1:0]);
         st_next.ld_oe = '1;
      end else if (c.local_high_half_en && !c.local_low_half_en) begin
         // High-half mode: upper byte only; bits 7..0 float, the controller does not drive them
         st_next.ld_o[15:8]  = ~dsrc[`ADRT_SYS_UB_HI:`ADRT_SYS_UB_LO];
         st_next.ld_oe[15:8] = '1;
      end

      // Low system half held for strobed output, loaded on the strobe edge
      if (lstb) begin
         st_next.sys_hold = adrt_cross16(p.ld);
      end
      if (p.la[`ADRT_A1_BIT]) begin
         sys_low = lstb ? adrt_cross16(p.ld) : st_reg.sys_hold;
      end else begin
         sys_low = adrt_cross16(p.ld);
      end

      // System port drive
      st_next.sys_o  = '0;
      st_next.sys_oe = '0;
      if (c.start_cycle && c.sys_out_en_n) begin
         // Start of cycle: address field only, other lines left to controller
         st_next.sys_o[`ADRT_AF_HI:`ADRT_AF_LO]  =
            ~p.la[`ADRT_AF_HI:`ADRT_AF_LO];
         st_next.sys_oe[`ADRT_AF_HI:`ADRT_AF_LO] = '1;
      end else if (!c.start_cycle && !c.sys_out_en_n) begin
         // Data out: upper byte always transparent, low half per A1
         st_next.sys_o[`ADRT_SYS_UB_HI:`ADRT_SYS_UB_LO] = ~p.ld[15:8];
         st_next.sys_o[`ADRT_DATA_W-1:0] = sys_low;
         st_next.sys_oe = '1;
      end
      // Start with output enabled is forbidden; the port then floats

      // Memory address drivers follow the live local address
      st_next.dram = adrt_dram_map(p.la, c.row_col_select);

      // Reset clears control and drive state; stored registers keep contents
      if (srst_in) begin
         st_next          = '0;
         st_next.addr_reg = st_reg.addr_reg;
         st_next.data_reg = st_reg.data_reg;
         st_next.sys_hold = st_reg.sys_hold;
         st_next.la_oe    = `ADRT_OE_RST;
         st_next.ld_oe    = {`ADRT_DATA_W{`ADRT_OE_RST}};
         st_next.sys_oe   = {`ADRT_SYS_W{`ADRT_OE_RST}};
         // Synchronisers restart at the idle level of the active-low enables,
         // so no enable is seen as asserted in the cycles after release
         st_next.meta.ctrl.addr_ack_n   = 1'b1;
         st_next.meta.ctrl.sys_out_en_n = 1'b1;
         st_next.samp.ctrl              = st_next.meta.ctrl;
      end
   end

   // State register
   always_ff @(posedge mclk_in) begin
      st_reg <= st_next;
   end

   // Link drive, straight from the state register
   assign link.sys_dev_o   = st_reg.sys_o;
   assign link.sys_dev_oe  = st_reg.sys_oe;
   assign link.ld_dev_o    = st_reg.ld_o;
   assign link.ld_dev_oe   = st_reg.ld_oe;
   assign link.dram_addr_out = st_reg.dram;

   // Only address bits 18..3 are ever driven by this end
   always_comb begin
      link.la_dev_o  = '0;
      link.la_dev_oe = '0;
      link.la_dev_o[`ADRT_AF_HI:`ADRT_AF_LO]  = st_reg.la_o;
      link.la_dev_oe[`ADRT_AF_HI:`ADRT_AF_LO] = {`ADRT_AF_W{st_reg.la_oe}};
   end

   // Observation outputs
   assign addr_reg_out = st_reg.addr_reg;
   assign data_reg_out = st_reg.data_reg;

endmodule : adrt_device_end

`default_nettype wire

/* adrt_host_end.sv */
`timescale 1ns/1ps
`default_nettype none

module adrt_host_end
   import adrt_pkg::*;
(
   // Clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          srst_in,
   // Link to the transceiver
   adrt_link_if.host_mp                       link,
   // Requested control levels
   input  wire adrt_ctrl_t                    user_ctrl_in,
   // Local address request
   input  wire logic [`ADRT_LA_HI:`ADRT_LA_LO] user_local_addr_in,
   input  wire logic                          user_local_addr_en_in,
   // Local data request
   input  wire logic [`ADRT_DATA_W-1:0]       user_local_data_in,
   input  wire logic                          user_local_data_en_in,
   // System port request
   input  wire logic [`ADRT_SYS_W-1:0]        user_sys_in,
   input  wire logic                          user_sys_en_in,
   // Synchronised view of the link lines
   output logic      [`ADRT_SYS_W-1:0]        sys_seen_out,
   output logic      [`ADRT_LA_HI:`ADRT_LA_LO] local_addr_seen_out,
   output logic      [`ADRT_DATA_W-1:0]       local_data_seen_out,
   output logic      [`ADRT_DRAM_W-1:0]       dram_seen_out
);

   adrt_host_state_t st_reg;  // Registered state
   adrt_host_state_t st_next; // Next state
   adrt_ctrl_t       c;       // Control levels after the guards

   // Next-state logic of the controller end
   always_comb begin
      st_next = st_reg;
      c       = user_ctrl_in;

      // Two-flop synchronisers on the lines coming back
      st_next.meta.sys  = link.sys_line;
      st_next.meta.la   = link.la_line;
      st_next.meta.ld   = link.ld_line;
      st_next.meta.dram = link.dram_addr_out;
      st_next.samp      = st_reg.meta;

      // Both data enables requested: the high-half one is dropped
      if (c.local_low_half_en && c.local_high_half_en) begin
         c.local_high_half_en = 1'b0;
      end
      // Output enable is refused while start cycle is high
      if (c.start_cycle) begin
         c.sys_out_en_n = 1'b1;
      end
      st_next.ctrl = c;

      // Local address, leaving 18..3 to the device while acknowledge is low
      st_next.la_o  = user_local_addr_in;
      st_next.la_oe = {`ADRT_LA_HI{user_local_addr_en_in}};
      if (!c.addr_ack_n) begin
         st_next.la_oe[`ADRT_AF_HI:`ADRT_AF_LO] = '0;
      end

      // Local data only while the device keeps both halves off
      st_next.ld_o  = user_local_data_in;
      st_next.ld_oe = user_local_data_en_in
                    & ~c.local_low_half_en & ~c.local_high_half_en;

      // System port: lines outside 18..3 during start of cycle, all lines on request while output enable is high
      st_next.sys_o  = user_sys_in;
      st_next.sys_oe = '0;
      if (c.start_cycle) begin
         st_next.sys_oe = '1;
         st_next.sys_oe[`ADRT_AF_HI:`ADRT_AF_LO] = '0;
      end else if (c.sys_out_en_n && user_sys_en_in) begin
         st_next.sys_oe = '1;
      end

      // Reset: controls idle, nothing driven
      if (srst_in) begin
         st_next                = '0;
         st_next.ctrl.addr_ack_n   = 1'b1;
         st_next.ctrl.sys_out_en_n = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk_in) begin
      st_reg <= st_next;
   end

   // Link drive and user view, straight from the state register
   assign link.ctrl        = st_reg.ctrl;
   assign link.la_host_o   = st_reg.la_o;
   assign link.la_host_oe  = st_reg.la_oe;
   assign link.ld_host_o   = st_reg.ld_o;
   assign link.ld_host_oe  = {`ADRT_DATA_W{st_reg.ld_oe}};
   assign link.sys_host_o  = st_reg.sys_o;
   assign link.sys_host_oe = st_reg.sys_oe;
   assign sys_seen_out        = st_reg.samp.sys;
   assign local_addr_seen_out = st_reg.samp.la;
   assign local_data_seen_out = st_reg.samp.ld;
   assign dram_seen_out       = st_reg.samp.dram;

endmodule : adrt_host_end

`default_nettype wire

/* adrt_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module adrt_checker
   import adrt_pkg::*;
(
   // Clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          srst_in,
   // Link signals, as the interface holds them
   input  wire adrt_ctrl_t                    ctrl,
   input  wire logic [`ADRT_SYS_W-1:0]        sys_line,
   input  wire logic [`ADRT_SYS_W-1:0]        sys_dev_o,
   input  wire logic [`ADRT_SYS_W-1:0]        sys_dev_oe,
   input  wire logic [`ADRT_LA_HI:`ADRT_LA_LO] la_line,
   input  wire logic [`ADRT_LA_HI:`ADRT_LA_LO] la_dev_o,
   input  wire logic [`ADRT_LA_HI:`ADRT_LA_LO] la_dev_oe,
   input  wire logic [`ADRT_DATA_W-1:0]       ld_line,
   input  wire logic [`ADRT_DATA_W-1:0]       ld_dev_o,
   input  wire logic [`ADRT_DATA_W-1:0]       ld_dev_oe,
   input  wire logic [`ADRT_DRAM_W-1:0]       dram_addr_out
);
   logic [2:0] live_reg;  // Edges since reset release, saturating
   logic [2:0] live_next; // Next count
   logic       live;      // Pipelines hold only post-reset pins

   // Hold checks off until the three-stage pin pipeline is refilled
   always_comb begin
      live_next = (live_reg == 3'h7) ? live_reg : live_reg + 3'h1;
   end
   always_ff @(posedge mclk_in) begin
      live_reg <= srst_in ? 3'h0 : live_next;
   end
   assign live = (live_reg == 3'h7);

   // Memory address expected from the local address lines
   function automatic logic [9:0] dram_exp(input logic [20:1] a, input logic rc);
      for (int i = 0; i < 10; i++) begin
         dram_exp[i] = rc ? a[2*i+1] : ~a[2*i+2];
      end
   endfunction : dram_exp

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   // Address capture clock rises, then the answer is due three edges on
   sequence addr_edge_s;
      live && !ctrl.addr_ack_n && $rose(ctrl.addr_capture_clk) ##3 1'b1;
   endsequence

   addr_capture_a: assert property (
      addr_edge_s |-> la_dev_o[18:3] == ~$past(sys_line[18:3], 3))
      else $error("stored address not driven");
   ack_float_a: assert property (
      live && $past(ctrl.addr_ack_n, 3) |-> la_dev_oe == '0)
      else $error("local address driven without acknowledge");
   ack_drive_a: assert property (
      live && !$past(ctrl.addr_ack_n, 3) |-> la_dev_oe[18:3] == 16'hffff)
      else $error("local address not enabled");
   data_float_a: assert property (
      live && $past(!ctrl.local_low_half_en && !ctrl.local_high_half_en, 3)
      |-> ld_dev_oe == '0)
      else $error("local data driven while disabled");
   low_half_a: assert property (
      live && $past(ctrl.local_low_half_en && !ctrl.local_high_half_en
                    && !ctrl.data_source_select, 3)
      |-> ld_dev_oe == 16'hffff
          && ld_dev_o == ~{$past(sys_line[7:0], 3), $past(sys_line[15:8], 3)})
      else $error("low half local data wrong");
   high_half_a: assert property (
      live && $past(!ctrl.local_low_half_en && ctrl.local_high_half_en
                    && !ctrl.data_source_select, 3)
      |-> ld_dev_oe == 16'hff00 && ld_dev_o[15:8] == ~$past(sys_line[23:16], 3))
      else $error("high half local data wrong");
   sys_float_a: assert property (
      live && $past(ctrl.sys_out_en_n && !ctrl.start_cycle, 3) |-> sys_dev_oe == '0)
      else $error("system port driven while disabled");
   start_addr_a: assert property (
      live && $past(ctrl.sys_out_en_n && ctrl.start_cycle, 3)
      |-> sys_dev_oe == 24'h07fff8 && sys_dev_o[18:3] == ~$past(la_line[18:3], 3))
      else $error("start address on system port wrong");
   out_transp_a: assert property (
      live && $past(!ctrl.sys_out_en_n && !ctrl.start_cycle && !la_line[1], 3)
      |-> sys_dev_oe == '1
          && sys_dev_o == ~{$past(ld_line[15:8], 3), $past(ld_line[7:0], 3),
                            $past(ld_line[15:8], 3)})
      else $error("transparent output wrong");
   dram_map_a: assert property (
      live |-> dram_addr_out == dram_exp($past(la_line, 3), $past(ctrl.row_col_select, 3)))
      else $error("memory address wrong");
   start_oe_excl_a: assert property (
      !(ctrl.start_cycle && !ctrl.sys_out_en_n))
      else $error("output enable asserted during start cycle");
   data_en_excl_a: assert property (
      !(ctrl.local_low_half_en && ctrl.local_high_half_en))
      else $error("both local data enables asserted");
endmodule : adrt_checker

`default_nettype wire

/* addr_data_registered_transceiver_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module addr_data_registered_transceiver_tb_top
   import adrt_pkg::*;
;
   localparam logic [23:0] A0 = 24'h5a3c96; // Addresses and data patterns
   localparam logic [23:0] A1 = 24'ha5c369;
   localparam logic [15:0] L0 = 16'h3ca5;
   localparam logic [15:0] L1 = 16'hc35a;

   logic        mclk_in;          // Bench clock
   logic        srst_in;          // Bench reset
   adrt_ctrl_t  uc;               // Requested control levels
   logic [20:1] ua;               // Local address request
   logic        ua_en;
   logic [15:0] ud;               // Local data request
   logic        ud_en;
   logic [23:0] us;               // System port request
   logic        us_en;
   logic [15:0] addr_reg;         // Device stored address
   logic [23:0] data_reg;         // Device stored data
   logic [23:0] sys_seen;         // Synchronised line views
   logic [20:1] la_seen;
   logic [15:0] ld_seen;
   logic [9:0]  dram_seen;
   int          n_errors;
   int          n_compared;

   adrt_link_if link ();
   adrt_device_end u_adrt_device_end (.mclk_in(mclk_in), .srst_in(srst_in), .link(link.dev_mp),
      .addr_reg_out(addr_reg), .data_reg_out(data_reg));
   adrt_host_end u_adrt_host_end (.mclk_in(mclk_in), .srst_in(srst_in), .link(link.host_mp),
      .user_ctrl_in(uc), .user_local_addr_in(ua), .user_local_addr_en_in(ua_en),
      .user_local_data_in(ud), .user_local_data_en_in(ud_en), .user_sys_in(us),
      .user_sys_en_in(us_en), .sys_seen_out(sys_seen), .local_addr_seen_out(la_seen),
      .local_data_seen_out(ld_seen), .dram_seen_out(dram_seen));
   adrt_checker u_adrt_checker (.mclk_in(mclk_in), .srst_in(srst_in), .ctrl(link.ctrl),
      .sys_line(link.sys_line), .sys_dev_o(link.sys_dev_o), .sys_dev_oe(link.sys_dev_oe),
      .la_line(link.la_line), .la_dev_o(link.la_dev_o), .la_dev_oe(link.la_dev_oe),
      .ld_line(link.ld_line), .ld_dev_o(link.ld_dev_o), .ld_dev_oe(link.ld_dev_oe),
      .dram_addr_out(link.dram_addr_out));

   // Free-running clock
   always #4 mclk_in = ~mclk_in;

   // Wait a number of rising edges
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : step

   // Compare and count
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Address capture, drive, hold and float
   task automatic t_addr;
      us <= A0; us_en <= 1'b1; step(8);
      uc.addr_capture_clk <= 1'b1; step(8);
      check(24'(addr_reg), 24'(A0[18:3]));
      uc.addr_ack_n <= 1'b0; step(8);
      check(24'(la_seen[18:3]), {8'h00, ~A0[18:3]});
      us <= A1; step(8);
      check(24'(la_seen[18:3]), {8'h00, ~A0[18:3]});
      uc.addr_capture_clk <= 1'b0; step(4);
      uc.addr_capture_clk <= 1'b1; step(8);
      check(24'(la_seen[18:3]), {8'h00, ~A1[18:3]});
      uc.addr_capture_clk <= 1'b0; uc.addr_ack_n <= 1'b1; step(8);
      check(24'(la_seen[18:3]), 24'h00ffff);
   endtask : t_addr

   // Row and column memory addresses
   task automatic t_dram;
      logic [9:0] e;
      ua <= 20'h9a5c3; ua_en <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         uc.row_col_select <= r[0]; step(8);
         for (int i = 0; i < 10; i++) e[i] = r[0] ? ua[2*i+1] : ~ua[2*i+2];
         check(24'(dram_seen), 24'(e));
      end
   endtask : t_dram

   // Local data modes, live and stored
   task automatic t_data;
      us <= A0; uc.local_low_half_en <= 1'b1; step(8);
      check(24'(ld_seen), {8'h00, ~A0[7:0], ~A0[15:8]});
      uc.local_low_half_en <= 1'b0; uc.local_high_half_en <= 1'b1; step(8);
      check(24'(ld_seen), 24'({~A0[23:16], 8'hff}));
      uc.local_high_half_en <= 1'b0; step(8);
      check(24'(ld_seen), 24'h00ffff);
      uc.data_source_select <= 1'b1; uc.local_low_half_en <= 1'b1;
      uc.data_capture_clk <= 1'b1; step(8);
      uc.data_capture_clk <= 1'b0; us <= A1; step(8);
      check(24'(ld_seen), {8'h00, ~A0[7:0], ~A0[15:8]});
      check(data_reg, A0);
      uc.data_capture_clk <= 1'b1; step(8);
      check(24'(ld_seen), {8'h00, ~A1[7:0], ~A1[15:8]});
      uc.data_capture_clk <= 1'b0; uc.data_source_select <= 1'b0;
      uc.local_low_half_en <= 1'b0; us_en <= 1'b0; step(4);
   endtask : t_data

   // System port output, strobed low half, float and start address
   task automatic t_out;
      ud <= L0; ud_en <= 1'b1; ua <= 20'h5a5a4; uc.sys_out_en_n <= 1'b0; step(8);
      check(sys_seen, ~{L0[15:8], L0[7:0], L0[15:8]});
      ua[1] <= 1'b1; uc.local_strobe <= 1'b1; step(8);
      uc.local_strobe <= 1'b0; ud <= L1; step(8);
      check(sys_seen, {~L1[15:8], ~L0[7:0], ~L0[15:8]});
      uc.local_strobe <= 1'b1; step(8);
      check(sys_seen, ~{L1[15:8], L1[7:0], L1[15:8]});
      uc.local_strobe <= 1'b0; uc.sys_out_en_n <= 1'b1; step(8);
      check(sys_seen, 24'hffffff);
      us <= 24'h000000; uc.start_cycle <= 1'b1; uc.sys_out_en_n <= 1'b0; step(8);
      check(sys_seen, {5'h00, ~ua[18:3], 3'h0});
      uc.start_cycle <= 1'b0; uc.sys_out_en_n <= 1'b1; ud_en <= 1'b0; ua_en <= 1'b0; step(4);
   endtask : t_out

   // Verdict and end of run
   task automatic conclude;
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      mclk_in = 1'b0; srst_in = 1'b1; n_errors = 0; n_compared = 0;
      uc = '0; uc.addr_ack_n = 1'b1; uc.sys_out_en_n = 1'b1;
      ua = '0; ua_en = 1'b0; ud = '0; ud_en = 1'b0; us = '0; us_en = 1'b0;
      step(20);
      srst_in <= 1'b0; step(4);
      t_addr();
      t_dram();
      t_data();
      t_out();
      conclude();
   end

   // Watchdog against a hang
   initial begin
      step(2000);
      n_errors++;
      conclude();
   end
endmodule : addr_data_registered_transceiver_tb_top

`default_nettype wire
